// ===== core/rar_ctrl.sv
// controller end: sequences rows, read launches and global transfer
//
// Contract
// [RULE1] row launches spaced at least 150 clocks
// [RULE2] quiet mode: read after clock 74, longer row
// [RULE3] unwanted columns discarded by controller itself
// [RULE4] controller sequences every row; sensor one line
// [RULE5] 11-bit row address picks one of 1728
// [RULE6] sensor accepts rows in any order
// [RULE7] vertical blank holds a 1us transfer pulse
// [RULE8] frame = rows x period + read + blank
// [RULE9] transfer may overlap the last row read
// [RULE10] sensor logic works up to 200 MHz
// [RULE11] read follows row launch; address held steady
// [RULE12] transfer pulse active low, high otherwise
`timescale 1ns/1ps
`default_nettype none
module rar_ctrl
    import rar_pkg::*;
#(
    parameter int ROW_CLK    = ROW_REC_CLK,
    parameter int Q_ROW_CLK  = QUIET_ROW_CLK,
    parameter int READ_DLY   = NORM_READ_DLY,
    parameter int Q_READ_DLY = QUIET_READ_DLY,
    parameter int TX_CYCLES  = TX_CYC
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    rar_link_if.ctrl                   link,
    input  wire logic                  row_valid_i,
    input  wire logic [ROW_ADDR_W-1:0] row_i,
    input  wire logic                  row_last_i,
    output logic                       row_ready_o,
    input  wire logic                  quiet_i,
    input  wire logic                  overlap_i,
    input  wire logic [COL_IDX_W-1:0]  col_first_i,
    input  wire logic [COL_IDX_W-1:0]  col_last_i,
    output logic                       busy_o,
    output logic                       vertical_blank_interval_o,
    output logic                       frame_done_o,
    output logic                       smp_valid_o,
    output logic [COL_IDX_W-1:0]       smp_col_o,
    output logic [COL_PORTS-1:0]       smp_keep_o,
    output logic [ROW_ADDR_W-1:0]      smp_row_o
);

    // ==========================================================
    // elaboration checks on the timing parameters
    if (ROW_CLK < ROW_MIN_CLK || ROW_CLK > 255) begin : g_bad_row
        $error("row period out of range");                // see [RULE1]
    end
    if (Q_ROW_CLK < QUIET_ROW_MIN_CLK || Q_ROW_CLK > 255) begin : g_bad_q
        $error("quiet row period out of range");          // see [RULE2]
    end
    if (Q_READ_DLY < QUIET_READ_DLY) begin : g_bad_qrd
        $error("quiet read launch too early");            // see [RULE2]
    end
    if (READ_DLY < 1 || READ_DLY >= ROW_CLK) begin : g_bad_rd
        $error("read launch must follow row launch");     // see [RULE11]
    end
    if (Q_READ_DLY + COL_CYC > 255) begin : g_bad_end
        $error("quiet read end does not fit the counter");
    end
    if (READ_DLY + COL_CYC > 255) begin : g_bad_nend
        $error("read end does not fit the counter");
    end
    if (TX_CYCLES < 1 || TX_CYCLES > 255) begin : g_bad_tx
        $error("transfer pulse length out of range");
    end

    // ==========================================================
    // state
    typedef struct packed {
        rar_ctrl_state_t       st;
        logic [CNT_W-1:0]      cnt;       // clocks since row launch
        logic [TX_CNT_W-1:0]   txcnt;     // clocks of transfer pulse
        logic [ROW_ADDR_W-1:0] row_addr;
        logic                  start_row;
        logic                  start_read;
        logic                  tx_n;
        logic                  last;      // current row ends the frame
        logic                  quiet;     // frame runs in quiet mode
        logic                  overlap;   // frame overlaps transfer
        logic                  frame_done;
        logic                  smp_valid;
        logic [COL_IDX_W-1:0]  smp_col;
        logic [COL_PORTS-1:0]  smp_keep;
        logic [ROW_ADDR_W-1:0] smp_row;
    } rar_ctrl_reg_t;

    localparam rar_ctrl_reg_t C_RST = '{
        st: RAR_C_IDLE, cnt: '1, txcnt: '0, row_addr: ROW_RST,
        start_row: 1'b0, start_read: 1'b0, tx_n: TX_N_IDLE,
        last: 1'b0, quiet: 1'b0, overlap: 1'b0, frame_done: 1'b0,
        smp_valid: 1'b0, smp_col: COL_RST, smp_keep: '0,
        smp_row: ROW_RST
    };

    // cycle marks, sized to the counter
    localparam logic [CNT_W-1:0] N_PER  = CNT_W'(ROW_CLK - 1);
    localparam logic [CNT_W-1:0] Q_PER  = CNT_W'(Q_ROW_CLK - 1);
    localparam logic [CNT_W-1:0] N_RD   = CNT_W'(READ_DLY);
    localparam logic [CNT_W-1:0] Q_RD   = CNT_W'(Q_READ_DLY);
    localparam logic [CNT_W-1:0] N_END  = CNT_W'(READ_DLY + COL_CYC);
    localparam logic [CNT_W-1:0] Q_END  = CNT_W'(Q_READ_DLY + COL_CYC);
    localparam logic [TX_CNT_W-1:0] TX_LAST = TX_CNT_W'(TX_CYCLES - 1);

    // ==========================================================
    // lane keep mask: lane j holds column base + j
    function automatic logic [COL_PORTS-1:0] keep_mask(
        input logic [COL_IDX_W-1:0] base,
        input logic [COL_IDX_W-1:0] first,
        input logic [COL_IDX_W-1:0] last
    );
        logic [COL_PORTS-1:0] m;
        logic [COL_IDX_W:0]   col;
        m = '0;
        for (int j = 0; j < COL_PORTS; j++) begin
            col = {1'b0, base} + (COL_IDX_W + 1)'(j);
            m[j] = (col >= {1'b0, first}) && (col <= {1'b0, last});
        end
        return m;
    endfunction : keep_mask

    rar_ctrl_reg_t        q;
    rar_ctrl_reg_t        next_q;
    logic [CNT_W-1:0]     per;
    logic [CNT_W-1:0]     rd;
    logic [CNT_W-1:0]     rd_end;
    logic                 accept;

    // ==========================================================
    // mode-dependent marks of the running row
    always_comb begin
        per    = q.quiet ? Q_PER : N_PER;                 // see [RULE2]
        rd     = q.quiet ? Q_RD  : N_RD;
        rd_end = q.quiet ? Q_END : N_END;
    end

    // next row taken only once the row period has elapsed
    assign row_ready_o = (q.st == RAR_C_IDLE) ||
                         (q.st == RAR_C_ROW && !q.last &&
                          q.cnt >= per);                  // see [RULE1]
    assign accept = row_valid_i && row_ready_o;

    // ==========================================================
    // sequencer: rows, read launch, vertical blank
    always_comb begin
        next_q = q;
        next_q.start_row  = 1'b0;
        next_q.start_read = 1'b0;
        next_q.frame_done = 1'b0;
        if (q.cnt != '1) begin
            next_q.cnt = q.cnt + 1'b1;
        end
        case (q.st)
            RAR_C_IDLE: begin
                next_q.quiet   = quiet_i;
                next_q.overlap = overlap_i;
            end
            RAR_C_ROW: begin
                // read launch a fixed delay after the row launch
                next_q.start_read = (q.cnt == rd - 1'b1); // see [RULE11]
                // last row: blank after its read, or overlapped with it
                if (q.last && ((q.overlap && q.cnt == rd) ||
                               q.cnt == rd_end)) begin    // see [RULE9]
                    next_q.st    = RAR_C_TX;
                    next_q.tx_n  = 1'b0;                  // see [RULE12]
                    next_q.txcnt = '0;
                end
            end
            RAR_C_TX: begin
                // transfer pulse lasts the blank time
                next_q.txcnt = q.txcnt + 1'b1;            // see [RULE7]
                if (q.txcnt == TX_LAST) begin
                    next_q.tx_n = TX_N_IDLE;              // see [RULE12]
                    next_q.st   = RAR_C_GAP;
                end
            end
            RAR_C_GAP: begin
                // frame closes once blank and row spacing are spent; the read end is not waited for
                if (q.cnt >= per) begin                   // see [RULE8]
                    next_q.st         = RAR_C_IDLE;
                    next_q.frame_done = 1'b1;
                end
            end
            default: next_q = C_RST;
        endcase
        // launch a row; address stays until the next launch
        if (accept) begin                                 // see [RULE4]
            next_q.st        = RAR_C_ROW;
            next_q.row_addr  = row_i;                     // see [RULE5]
            next_q.last      = row_last_i;
            next_q.start_row = 1'b1;
            next_q.cnt       = '0;                        // see [RULE11]
        end
        // sample path keeps only columns inside the window
        next_q.smp_valid = link.col_valid;
        next_q.smp_col   = link.col_index;
        next_q.smp_row   = link.line_row;
        next_q.smp_keep  = link.col_valid ?
            keep_mask(link.col_index, col_first_i, col_last_i) :
            '0;                                           // see [RULE3]
    end

    // state register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= C_RST;
        end else begin
            q <= next_q;
        end
    end

    // ==========================================================
    // outputs
    assign link.row_addr  = q.row_addr;
    assign link.start_row = q.start_row;
    assign link.start_read = q.start_read;
    assign link.tx_n      = q.tx_n;
    assign busy_o         = (q.st != RAR_C_IDLE);
    assign vertical_blank_interval_o = (q.st == RAR_C_TX);
    assign frame_done_o   = q.frame_done;
    assign smp_valid_o    = q.smp_valid;
    assign smp_col_o      = q.smp_col;
    assign smp_keep_o     = q.smp_keep;
    assign smp_row_o      = q.smp_row;

endmodule : rar_ctrl
`default_nettype wire

// ===== core/rar_pkg.sv
// row readout sequencing: shared constants and state encodings
package rar_pkg;

    // ==========================================================
    // array geometry and addressing
    localparam int ROW_ADDR_W = 11;       // row address width
    localparam int NUM_ROWS   = 1728;     // addressable rows
    localparam int NUM_COLS   = 2368;     // columns in every row read
    localparam int COL_PORTS  = 16;       // columns presented per clock
    localparam int COL_IDX_W  = 12;       // column index width
    localparam int COL_CYC    = (NUM_COLS + COL_PORTS - 1) / COL_PORTS;

    // ==========================================================
    // row timing in sensor clocks
    localparam int ROW_MIN_CLK       = 150; // least row spacing
    localparam int ROW_REC_CLK       = 158; // usual row spacing
    localparam int NORM_READ_DLY     = 1;   // read launch after row launch
    localparam int QUIET_READ_DLY    = 74;  // quiet read launch delay
    localparam int QUIET_ROW_MIN_CLK = 210; // quiet row period, low end
    localparam int QUIET_ROW_CLK     = 222; // quiet row period, high end

    // ==========================================================
    // clock and global transfer timing
    localparam int SYS_CLK_MHZ    = 40;   // system clock rate
    localparam int SENSOR_MAX_MHZ = 200;  // fastest clock for sensor logic
    localparam int TX_TIME_NS     = 1000; // global transfer pulse length
    localparam int TX_CYC = (TX_TIME_NS * SYS_CLK_MHZ + 999) / 1000;

    // ==========================================================
    // counter widths and reset values
    localparam int       CNT_W      = 8;
    localparam int       TX_CNT_W   = 8;
    localparam logic     TX_N_IDLE  = 1'b1; // transfer pulse released
    localparam logic [ROW_ADDR_W-1:0] ROW_RST = 11'h000;
    localparam logic [COL_IDX_W-1:0]  COL_RST = 12'h000;

    // ==========================================================
    // state encodings (gray along the usual path)
    typedef enum logic [1:0] {
        RAR_C_IDLE = 2'h0,
        RAR_C_ROW  = 2'h1,
        RAR_C_TX   = 2'h3,
        RAR_C_GAP  = 2'h2
    } rar_ctrl_state_t;

    typedef enum logic {
        RAR_S_IDLE = 1'h0,
        RAR_S_READ = 1'h1
    } rar_sens_state_t;

endpackage : rar_pkg

// ===== core/rar_link_if.sv
// row readout link between camera controller and sensor
`timescale 1ns/1ps
`default_nettype none
interface rar_link_if
    import rar_pkg::*;
();
    logic [ROW_ADDR_W-1:0] row_addr;   // selected row
    logic                  start_row;  // row cycle launch, one clock
    logic                  start_read; // read phase launch, one clock
    logic                  tx_n;       // global transfer, active low
    logic                  col_valid;  // column group present
    logic [COL_IDX_W-1:0]  col_index;  // first column of the group
    logic [ROW_ADDR_W-1:0] line_row;   // row being read out

    // ==========================================================
    // controller end
    modport ctrl (
        output row_addr,
        output start_row,
        output start_read,
        output tx_n,
        input  col_valid,
        input  col_index,
        input  line_row
    );

    // ==========================================================
    // sensor end
    modport sensor (
        input  row_addr,
        input  start_row,
        input  start_read,
        input  tx_n,
        output col_valid,
        output col_index,
        output line_row
    );
endinterface : rar_link_if
`default_nettype wire

// ===== core/rar_sensor.sv
// sensor end: takes row commands and reads every column of a row
`timescale 1ns/1ps
`default_nettype none
module rar_sensor
    import rar_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    rar_link_if.sensor                 link,
    output logic                       reading_o,
    output logic                       line_done_o,
    output logic [ROW_ADDR_W-1:0]      line_row_o,
    output logic                       addr_err_o,
    output logic                       xfer_active_o,
    output logic                       xfer_done_o
);

    // ==========================================================
    // elaboration checks
    if (COL_CYC * COL_PORTS < NUM_COLS) begin : g_bad_cols
        $error("column groups do not cover the row");
    end
    if (SYS_CLK_MHZ > SENSOR_MAX_MHZ) begin : g_bad_clk
        $error("clock above the rate the sensor logic serves");
    end

    // ==========================================================
    // state
    typedef struct packed {
        rar_sens_state_t       st;
        logic [ROW_ADDR_W-1:0] row_lat;   // row selected by last launch
        logic                  row_ok;    // a launched row awaits read
        logic [CNT_W-1:0]      colcnt;
        logic                  col_valid;
        logic [COL_IDX_W-1:0]  col_index;
        logic [ROW_ADDR_W-1:0] line_row;
        logic                  line_done;
        logic                  addr_err;
        logic                  tx_prev;
        logic                  xfer_done;
    } rar_sens_reg_t;

    localparam rar_sens_reg_t S_RST = '{
        st: RAR_S_IDLE, row_lat: ROW_RST, row_ok: 1'b0, colcnt: '0,
        col_valid: 1'b0, col_index: COL_RST, line_row: ROW_RST,
        line_done: 1'b0, addr_err: 1'b0, tx_prev: TX_N_IDLE,
        xfer_done: 1'b0
    };
    localparam logic [CNT_W-1:0] COL_LAST = CNT_W'(COL_CYC - 1);
    localparam logic [ROW_ADDR_W-1:0] ROW_LIM = ROW_ADDR_W'(NUM_ROWS);

    rar_sens_reg_t q;
    rar_sens_reg_t next_q;

    // ==========================================================
    // next state; fully synchronous, for clocks up to SENSOR_MAX_MHZ
    always_comb begin                                    // see [RULE10]
        next_q = q;
        next_q.line_done = 1'b0;
        next_q.addr_err  = 1'b0;
        next_q.tx_prev   = link.tx_n;
        next_q.xfer_done = !q.tx_prev && link.tx_n;  // end of transfer
        // no frame engine: one line per commanded read
        case (q.st)                                      // see [RULE4]
            RAR_S_IDLE: begin
                if (link.start_read && q.row_ok) begin
                    next_q.st        = RAR_S_READ;
                    next_q.row_ok    = 1'b0;
                    next_q.colcnt    = '0;
                    next_q.col_valid = 1'b1;
                    next_q.col_index = COL_RST;
                    next_q.line_row  = q.row_lat;
                end
            end
            RAR_S_READ: begin
                // every column group goes out, no horizontal window
                if (q.colcnt == COL_LAST) begin          // see [RULE3]
                    next_q.st        = RAR_S_IDLE;
                    next_q.col_valid = 1'b0;
                    next_q.line_done = 1'b1;
                end else begin
                    next_q.colcnt    = q.colcnt + 1'b1;
                    next_q.col_index = q.col_index + COL_IDX_W'(COL_PORTS);
                end
            end
            default: next_q = S_RST;
        endcase
        // any row in any order; only out-of-array rows are refused
        if (link.start_row) begin                        // see [RULE6]
            if (link.row_addr < ROW_LIM) begin
                next_q.row_lat = link.row_addr;
                next_q.row_ok  = 1'b1;
            end else begin
                next_q.addr_err = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= S_RST;
        end else begin
            q <= next_q;
        end
    end

    // ==========================================================
    // outputs
    assign link.col_valid = q.col_valid;
    assign link.col_index = q.col_index;
    assign link.line_row  = q.line_row;
    assign reading_o      = (q.st == RAR_S_READ);
    assign line_done_o    = q.line_done;
    assign line_row_o     = q.line_row;
    assign addr_err_o     = q.addr_err;
    assign xfer_active_o  = !q.tx_prev;
    assign xfer_done_o    = q.xfer_done;

endmodule : rar_sensor
`default_nettype wire

// ===== test/rar_assertions.sv
// concurrent checks on the controller-to-sensor row link
`timescale 1ns/1ps
`default_nettype none
module rar_assertions
    import rar_pkg::*;
#(
    parameter int TX_CYCLES = TX_CYC
) (
    input wire logic                  sys_clk_i,
    input wire logic                  rst_i,
    input wire logic [ROW_ADDR_W-1:0] row_addr,
    input wire logic                  start_row,
    input wire logic                  start_read,
    input wire logic                  tx_n,
    input wire logic                  col_valid,
    input wire logic [COL_IDX_W-1:0]  col_index,
    input wire logic [ROW_ADDR_W-1:0] line_row
);
    localparam logic [7:0] TX_LEN  = 8'(TX_CYCLES);
    localparam logic [7:0] MIN_GAP = 8'(ROW_MIN_CLK - 1);
    localparam logic [7:0] Q_SINCE = 8'(QUIET_READ_DLY - 1);
    localparam logic [COL_IDX_W-1:0] LAST_IDX = 12'h930;

    // ==========================================================
    // helper state: clocks since row launch, transfer pulse length
    typedef struct packed {
        logic [7:0] since_row;
        logic [7:0] tx_low;
    } rar_chk_t;
    rar_chk_t cur;
    rar_chk_t next_cur;

    // next helper state, both counts saturate
    always_comb begin
        next_cur = cur;
        if (start_row) begin
            next_cur.since_row = 8'h00;
        end else if (cur.since_row != 8'hff) begin
            next_cur.since_row = cur.since_row + 8'h01;
        end
        if (tx_n) begin
            next_cur.tx_low = 8'h00;
        end else if (cur.tx_low != 8'hff) begin
            next_cur.tx_low = cur.tx_low + 8'h01;
        end
    end

    // register helper state
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur <= '{since_row: 8'hff, tx_low: 8'h00};
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    chk_row_spacing: assert property (
        start_row |-> cur.since_row >= MIN_GAP)
        else $error("row launches too close");
    chk_read_delay: assert property (
        start_read |-> (cur.since_row == 8'h00 || cur.since_row == Q_SINCE))
        else $error("read launch at wrong distance from row launch");
    chk_addr_held: assert property (
        !start_row |-> $stable(row_addr))
        else $error("row address moved between launches");
    chk_read_start: assert property (
        start_read |=> col_valid && col_index == COL_RST
                       && line_row == $past(row_addr))
        else $error("read did not start on the launched row");
    chk_col_step: assert property (
        col_valid && $past(col_valid) |->
            col_index == $past(col_index) + 12'h010)
        else $error("column groups not consecutive");
    chk_all_columns: assert property (
        $fell(col_valid) |-> $past(col_index) == LAST_IDX)
        else $error("row read ended before last column");
    chk_tx_length: assert property (
        $rose(tx_n) |-> cur.tx_low == TX_LEN)
        else $error("transfer pulse length wrong");
    chk_blank_quiet: assert property (
        !tx_n |-> !start_row)
        else $error("row launched during vertical blank");
    chk_burst_hold: assert property (
        $rose(col_valid) |-> col_valid [*8])
        else $error("column burst collapsed");

    // main scenarios reached
    cov_quiet_read: cover property (start_read && cur.since_row == Q_SINCE);
    cov_overlap: cover property (!tx_n && col_valid);
    cov_tx_end: cover property ($rose(tx_n));
endmodule : rar_assertions
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench: controller and sensor joined over the row link
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rar_pkg::*;
();
    logic                  sys_clk_i, rst_i, row_valid_i, row_last_i;
    logic                  quiet_i, overlap_i, row_ready_o, busy_o;
    logic                  vertical_blank_interval_o, frame_done_o;
    logic                  smp_valid_o, reading_o, line_done_o;
    logic                  addr_err_o, xfer_active_o, xfer_done_o;
    logic [ROW_ADDR_W-1:0] row_i, smp_row_o, line_row_o;
    logic [COL_IDX_W-1:0]  col_first_i, col_last_i, smp_col_o;
    logic [COL_PORTS-1:0]  smp_keep_o;
    logic [ROW_ADDR_W-1:0] frame_rows[$];
    logic [31:0]           got_q[$];
    int                    gap_q[$];
    int                    keep_sum, vb_cnt, read_cnt, xa_cnt, xd_cnt;
    int                    ae_cnt, ovl_cnt, gcnt, err_total, comparisons;

    rar_link_if i_rar_link_if ();
    rar_ctrl i_rar_ctrl (.sys_clk_i, .rst_i, .link(i_rar_link_if),
        .row_valid_i, .row_i, .row_last_i, .row_ready_o, .quiet_i,
        .overlap_i, .col_first_i, .col_last_i, .busy_o,
        .vertical_blank_interval_o, .frame_done_o, .smp_valid_o,
        .smp_col_o, .smp_keep_o, .smp_row_o);
    rar_sensor i_rar_sensor (.sys_clk_i, .rst_i, .link(i_rar_link_if),
        .reading_o, .line_done_o, .line_row_o, .addr_err_o,
        .xfer_active_o, .xfer_done_o);
    rar_assertions #(.TX_CYCLES(TX_CYC)) i_rar_assertions (.sys_clk_i,
        .rst_i, .row_addr(i_rar_link_if.row_addr),
        .start_row(i_rar_link_if.start_row),
        .start_read(i_rar_link_if.start_read),
        .tx_n(i_rar_link_if.tx_n), .col_valid(i_rar_link_if.col_valid),
        .col_index(i_rar_link_if.col_index),
        .line_row(i_rar_link_if.line_row));

    // ==========================================================
    // clock, 25 ns period
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // monitor: lines read, kept samples, pulse lengths, row spacing
    always @(negedge sys_clk_i) begin
        if (!rst_i) begin
            if (line_done_o === 1'b1) got_q.push_back(32'(line_row_o));
            if (smp_valid_o === 1'b1) keep_sum += $countones(smp_keep_o);
            vb_cnt += int'(vertical_blank_interval_o === 1'b1);
            read_cnt += int'(reading_o === 1'b1);
            xa_cnt += int'(xfer_active_o === 1'b1);
            xd_cnt += int'(xfer_done_o === 1'b1);
            ae_cnt += int'(addr_err_o === 1'b1);
            if (i_rar_link_if.tx_n === 1'b0 && i_rar_link_if.col_valid === 1'b1)
                ovl_cnt++;
            if (i_rar_link_if.start_row === 1'b1) begin
                gap_q.push_back(gcnt);
                gcnt = 1;
            end else begin
                gcnt++;
            end
        end
    end

    // ==========================================================
    // tasks
    task automatic compare(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s got %0h expected %0h",
                     $time, what, got, exp);
        end
    endtask : compare

    // request one row, hold it until the controller takes it
    task automatic send_row(input logic [ROW_ADDR_W-1:0] r,
                            input logic last);
        int n;
        row_i <= r;
        row_last_i <= last;
        row_valid_i <= 1'b1;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (row_ready_o !== 1'b1 && n < 1000);
        if (n >= 1000) compare(32'h0, 32'h1, "row request stalled");
        @(posedge sys_clk_i);
    endtask : send_row

    // run one frame of frame_rows and check what it produced
    task automatic run_frame(input logic q, input logic ov,
                             input logic [COL_IDX_W-1:0] f,
                             input logic [COL_IDX_W-1:0] l);
        int b_keep, b_vb, b_rd, b_xa, b_xd, b_ovl, b_got, b_gap, n, k;
        @(negedge sys_clk_i);
        b_keep = keep_sum;
        b_vb = vb_cnt;
        b_rd = read_cnt;
        b_xa = xa_cnt;
        b_xd = xd_cnt;
        b_ovl = ovl_cnt;
        b_got = got_q.size();
        b_gap = gap_q.size();
        n = frame_rows.size();
        @(posedge sys_clk_i);
        quiet_i <= q;
        overlap_i <= ov;
        col_first_i <= f;
        col_last_i <= l;
        @(posedge sys_clk_i);
        foreach (frame_rows[i]) send_row(frame_rows[i], i == n - 1);
        row_valid_i <= 1'b0;
        k = 0;
        do begin
            @(negedge sys_clk_i);
            k++;
        end while (frame_done_o !== 1'b1 && k < 3000);
        compare(32'(k < 3000), 32'h1, "frame never ended");
        repeat (3) @(negedge sys_clk_i);
        compare(got_q.size() - b_got, n, "lines read");
        for (k = 0; k < n; k++)
            compare(got_q[b_got+k], 32'(frame_rows[k]), "row");
        for (k = 1; k < n; k++)
            compare(gap_q[b_gap+k], q ? QUIET_ROW_CLK : ROW_REC_CLK,
                    "row spacing");
        compare(keep_sum - b_keep, n * (l - f + 1), "kept");
        compare(read_cnt - b_rd, n * COL_CYC, "read cycles");
        compare(vb_cnt - b_vb, TX_CYC, "blank length");
        compare(xa_cnt - b_xa, TX_CYC, "transfer seen");
        compare(xd_cnt - b_xd, 1, "transfer ends");
        compare(32'(ovl_cnt > b_ovl), 32'(ov), "overlap");
        compare(32'(busy_o), 32'h0, "busy after frame");
        $display("test done: %0d rows quiet %0d overlap %0d", n, q, ov);
    endtask : run_frame

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // watchdog, far beyond four frames
    initial begin
        #(20000 * 25);
        err_total++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        wrap_up();
    end

    // main sequence
    initial begin
        {rst_i, row_valid_i, row_last_i, quiet_i, overlap_i} = 5'h10;
        row_i = 11'h000;
        col_first_i = 12'h000;
        col_last_i = 12'h93f;
        {keep_sum, vb_cnt, read_cnt, xa_cnt, xd_cnt} = '0;
        {ae_cnt, ovl_cnt, gcnt, err_total, comparisons} = '0;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        frame_rows = '{11'h005, 11'h6bf, 11'h000, 11'h384};
        run_frame(1'b0, 1'b0, 12'h000, 12'h93f);
        frame_rows = '{11'h003, 11'h002};
        run_frame(1'b1, 1'b0, 12'h00a, 12'h019);
        frame_rows = '{11'h007, 11'h007};
        run_frame(1'b0, 1'b1, 12'h930, 12'h93f);
        frame_rows = '{11'h6be};
        run_frame(1'b1, 1'b1, 12'h93f, 12'h93f);
        compare(ae_cnt, 0, "address errors");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
